// *** rtl/dic_pkg.sv ***
// shared constants and types of the digital input conditioner
`default_nettype none

package dic_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS   = 20;
    localparam int SCAN_PERIOD_NS  = 5_000_000;
    localparam int SCAN_CYCLES_DEF = (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCAN_MS         = 5;
    localparam int AC_EXTRA_MS     = 30;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int CHANNELS_DEF = 8;
    localparam int VOLT_W       = 19;
    localparam int MV_W         = 20;
    localparam int THR_W        = 12;
    localparam int DLY_W        = 21;
    localparam int ELAPSED_W    = 22;
    localparam int CNT_W        = 32;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;

    ////////////////////////////////////////////////////////////////////////////
    // scaling of 0.1 V threshold steps to the 1 mV voltage grid
    localparam logic [MV_W-1:0] MV_PER_THR    = 20'h00064;
    localparam logic [MV_W-1:0] AC_MV_PER_THR = 20'h0000a;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [THR_W-1:0] ACT_THR_RST = 12'h370;
    localparam logic [THR_W-1:0] REL_THR_RST = 12'h258;
    localparam logic [DLY_W-1:0] DLY_RST     = 21'h000000;
    localparam logic             POL_RST     = 1'h0;
    localparam logic             AC_RST      = 1'h0;

    ////////////////////////////////////////////////////////////////////////////
    // register map: addr[6:4] channel, addr[3:0] register
    localparam int               CH_LSB          = 4;
    localparam int               CH_W            = 3;
    localparam logic [3:0]       REG_CFG         = 4'h0;
    localparam logic [3:0]       REG_ACT_THR     = 4'h1;
    localparam logic [3:0]       REG_REL_THR     = 4'h2;
    localparam logic [3:0]       REG_ACT_DLY     = 4'h3;
    localparam logic [3:0]       REG_DROP_DLY    = 4'h4;
    localparam logic [3:0]       REG_COUNT       = 4'h5;
    localparam logic [3:0]       REG_CLEAR       = 4'h6;
    localparam logic [3:0]       REG_VOLT        = 4'h7;
    localparam logic [3:0]       REG_STATE       = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS_ALL = 8'h80;
    localparam int               CFG_POL_BIT     = 0;
    localparam int               CFG_AC_BIT      = 1;
    localparam int               CLR_BIT         = 0;
    localparam int               ST_STATUS_BIT   = 0;
    localparam int               ST_RAW_BIT      = 1;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic {
        CLR_IDLE = 1'b0,
        CLR_DO   = 1'b1
    } dic_clr_e;

    typedef struct packed {
        logic             pol;
        logic             ac;
        logic [THR_W-1:0] actThr;
        logic [THR_W-1:0] relThr;
        logic [DLY_W-1:0] actDly;
        logic [DLY_W-1:0] dropDly;
    } dic_cfg_s;

    localparam dic_cfg_s CFG_RST = '{pol: POL_RST, ac: AC_RST, actThr: ACT_THR_RST,
                                     relThr: REL_THR_RST, actDly: DLY_RST,
                                     dropDly: DLY_RST};

endpackage : dic_pkg

`default_nettype wire

// *** rtl/dic_scan_tick.sv ***
// divider that makes the one-cycle scan enable
`default_nettype none

module dic_scan_tick
    import dic_pkg::*;
#(
    parameter int unsigned PERIOD = SCAN_CYCLES_DEF
)
(
    input  wire logic clock,
    input  wire logic rst_n,
    output var  logic tick
);

    logic [31:0] count_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count_q <= 32'h00000000;
            tick    <= 1'b0;
        end
        else if (count_q >= 32'(PERIOD - 1))
        begin
            count_q <= 32'h00000000;
            tick    <= 1'b1;
        end
        else
        begin
            count_q <= count_q + 32'h00000001;
            tick    <= 1'b0;
        end
    end

endmodule : dic_scan_tick

`default_nettype wire

// *** rtl/dic_input_conditioner.sv ***
// digital input conditioner: thresholds, polarity, delays, counters, registers
//
// Contract
// [R1] polarity 0 reports energized as 1, polarity 1 as 0; default 0
// [R2] activation threshold in 0.1 V steps, default 88 V; above it activates
// [R3] with polarity 1, voltage above activation threshold deactivates the input
// [R4] release threshold default 60 V; below it releases the raw input
// [R5] 0-to-1 status change delayed by activation delay in ms, default 0
// [R6] 1-to-0 status change delayed by drop-off time in ms, default 0
// [R7] alternating supply mode adds 30 ms to deactivation; default off
// [R8] alternating supply mode uses 10 percent of activation as release threshold
// [R9] 32-bit count of status rises, reset to 0
// [R10] writing 1 to the clear control zeroes that channel's count
// [R11] measured voltage of each channel readable in mV
// [R12] each channel keeps its own thresholds
// [R13] inputs sampled and updated once every 5 ms scan
// [R14] between thresholds raw state holds; pending delay restarts on revert
//
// The strobed register port and the register offsets are this design's own decisions.
`default_nettype none

module dic_input_conditioner
    import dic_pkg::*;
#(
    parameter int unsigned CHANNELS    = CHANNELS_DEF,
    parameter int unsigned SCAN_CYCLES = SCAN_CYCLES_DEF
)
(
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wrData,
    input  wire logic                wrEn,
    input  wire logic                rdEn,
    output var  logic [DATA_W-1:0]   rdData,
    input  wire logic [VOLT_W-1:0]   voltIn [CHANNELS],
    output var  logic [CHANNELS-1:0] statusOut
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode helpers

    function automatic logic [CH_W-1:0] chanOf(input logic [ADDR_W-1:0] a);
        return a[CH_LSB +: CH_W];
    endfunction : chanOf

    function automatic logic [3:0] regOf(input logic [ADDR_W-1:0] a);
        return a[3:0];
    endfunction : regOf

    function automatic logic chanHit(input logic [ADDR_W-1:0] a);
        return !a[ADDR_W-1] && (32'(chanOf(a)) < CHANNELS);
    endfunction : chanHit

    ////////////////////////////////////////////////////////////////////////////
    // scan enable

    logic scanTick;

    dic_scan_tick #(
        .PERIOD (SCAN_CYCLES)
    ) u_tick (
        .clock (clock),
        .rst_n (rst_n),
        .tick  (scanTick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // per-channel state

    dic_cfg_s               cfg_q     [CHANNELS];
    logic [CHANNELS-1:0]    raw_q;
    logic [CHANNELS-1:0]    status_q;
    logic [CHANNELS-1:0]    rise_q;
    logic [CHANNELS-1:0]    clr_q;
    logic [ELAPSED_W-1:0]   elapsed_q [CHANNELS];
    logic [CNT_W-1:0]       count_q   [CHANNELS];
    logic [CHANNELS-1:0]    rawNext;
    logic [CHANNELS-1:0]    target;
    logic [CHANNELS-1:0]    expired;
    logic [MV_W-1:0]        actMv     [CHANNELS];
    logic [MV_W-1:0]        relMv     [CHANNELS];
    logic [ELAPSED_W-1:0]   need      [CHANNELS];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    logic               wrHit;
    logic [CH_W-1:0]    wrCh;

    assign wrHit = wrEn && chanHit(addr);
    assign wrCh  = chanOf(addr);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int c = 0; c < CHANNELS; c++)
            begin
                cfg_q[c] <= CFG_RST;
            end
        end
        else if (wrHit)
        begin
            case (regOf(addr))
                REG_CFG:
                begin
                    cfg_q[wrCh].pol <= wrData[CFG_POL_BIT];
                    cfg_q[wrCh].ac  <= wrData[CFG_AC_BIT];
                end
                REG_ACT_THR:  cfg_q[wrCh].actThr  <= wrData[THR_W-1:0];  // see [R12]
                REG_REL_THR:  cfg_q[wrCh].relThr  <= wrData[THR_W-1:0];
                REG_ACT_DLY:  cfg_q[wrCh].actDly  <= wrData[DLY_W-1:0];
                REG_DROP_DLY: cfg_q[wrCh].dropDly <= wrData[DLY_W-1:0];
                default:      ;
            endcase
        end
    end

    // clear command becomes a one-cycle pulse per channel
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            clr_q <= '0;
        end
        else
        begin
            for (int c = 0; c < CHANNELS; c++)
            begin
                clr_q[c] <= wrHit && (32'(wrCh) == c) && (regOf(addr) == REG_CLEAR)
                            && (dic_clr_e'(wrData[CLR_BIT]) == CLR_DO);  // see [R10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conditioning, one copy per channel

    for (genvar i = 0; i < CHANNELS; i++)
    begin : g_ch
        logic [MV_W-1:0] vMv;
        logic            aboveAct;
        logic            belowRel;

        assign vMv      = {1'b0, voltIn[i]};
        assign actMv[i] = {8'h00, cfg_q[i].actThr} * MV_PER_THR;  // see [R2]
        // ac mode derives release from activation, programmed value unused
        assign relMv[i] = cfg_q[i].ac ? {8'h00, cfg_q[i].actThr} * AC_MV_PER_THR  // see [R8]
                                      : {8'h00, cfg_q[i].relThr} * MV_PER_THR;
        assign aboveAct = vMv > actMv[i];
        assign belowRel = vMv < relMv[i];  // see [R4]
        // hysteresis band keeps the last raw level; activation wins if misconfigured
        assign rawNext[i] = aboveAct ? 1'b1 : (belowRel ? 1'b0 : raw_q[i]);  // see [R14]
        assign target[i]  = rawNext[i] ^ cfg_q[i].pol;  // see [R1] see [R3]
        assign need[i]    = target[i] ? {1'b0, cfg_q[i].actDly}  // see [R5]
                          : {1'b0, cfg_q[i].dropDly}             // see [R6]
                            + (cfg_q[i].ac ? 22'(AC_EXTRA_MS) : 22'h000000);  // see [R7]
        assign expired[i] = elapsed_q[i] >= need[i];

        always_ff @(posedge clock)
        begin
            if (!rst_n)
            begin
                raw_q[i] <= 1'b0;
            end
            else if (scanTick)
            begin
                raw_q[i] <= rawNext[i];  // see [R13]
            end
        end

        always_ff @(posedge clock)
        begin
            if (!rst_n)
            begin
                status_q[i]  <= 1'b0;
                elapsed_q[i] <= '0;
            end
            else if (scanTick)
            begin
                if (target[i] == status_q[i])
                begin
                    elapsed_q[i] <= '0;  // see [R14]
                end
                else if (expired[i])
                begin
                    status_q[i]  <= target[i];  // see [R13]
                    elapsed_q[i] <= '0;
                end
                else if (elapsed_q[i] < {ELAPSED_W{1'b1}} - 22'(SCAN_MS))
                begin
                    // time is counted in whole scans, so delays resolve to 5 ms
                    elapsed_q[i] <= elapsed_q[i] + 22'(SCAN_MS);
                end
            end
        end

        always_ff @(posedge clock)
        begin
            if (!rst_n)
            begin
                rise_q[i] <= 1'b0;
            end
            else
            begin
                rise_q[i] <= scanTick && target[i] && !status_q[i] && expired[i];
            end
        end

        // a rise in the clearing cycle is kept, so the count restarts at one
        always_ff @(posedge clock)
        begin
            if (!rst_n)
            begin
                count_q[i] <= '0;
            end
            else if (rise_q[i])
            begin
                count_q[i] <= clr_q[i] ? 32'h00000001 : count_q[i] + 32'h00000001;  // see [R9]
            end
            else if (clr_q[i])
            begin
                count_q[i] <= '0;  // see [R10]
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // checks

        sequence scanAbove;
            scanTick && (vMv > actMv[i]);
        endsequence

        sequence scanBelow;
            scanTick && (vMv < relMv[i]) && (vMv <= actMv[i]);
        endsequence

        status_on_scan_a: assert property ($changed(status_q[i]) |-> $past(scanTick))  // see [R13]
            else $error("status moved outside a scan");

        no_pickup_a: assert property (scanAbove ##0 (!cfg_q[i].pol && cfg_q[i].actDly == 0)
                                      |=> status_q[i])  // see [R2]
            else $error("energized normally open input not active");

        nc_dropout_a: assert property (scanAbove ##0 (cfg_q[i].pol && !cfg_q[i].ac
                                       && cfg_q[i].dropDly == 0) |=> !status_q[i])  // see [R3]
            else $error("energized normally closed input still active");

        release_low_a: assert property (scanBelow |=> !raw_q[i] ##1 !raw_q[i] [*2])  // see [R4]
            else $error("raw input not released below threshold");

        ac_release_a: assert property (scanTick && cfg_q[i].ac
                                       && vMv < {8'h00, cfg_q[i].actThr} * AC_MV_PER_THR
                                       && vMv <= actMv[i] |=> !raw_q[i])  // see [R8]
            else $error("ac release threshold not applied");

        pickup_delay_a: assert property ($rose(status_q[i])
                                         |-> $past(elapsed_q[i]) >= {1'b0, $past(cfg_q[i].actDly)})  // see [R5]
            else $error("activation before its delay");

        drop_delay_a: assert property ($fell(status_q[i])
                                       |-> $past(elapsed_q[i]) >= {1'b0, $past(cfg_q[i].dropDly)})  // see [R6]
            else $error("deactivation before its delay");

        ac_extra_a: assert property ($fell(status_q[i]) && $past(cfg_q[i].ac)
                                     |-> $past(elapsed_q[i]) >= 22'(AC_EXTRA_MS))  // see [R7]
            else $error("ac deactivation shorter than 30 ms");

        count_rise_a: assert property ($rose(status_q[i]) && !clr_q[i]
                                       |=> count_q[i] == $past(count_q[i]) + 32'h00000001)  // see [R9]
            else $error("rise not counted once");

        count_clear_a: assert property (clr_q[i] && !rise_q[i] |=> count_q[i] == 32'h00000000)  // see [R10]
            else $error("count not cleared");

        band_hold_a: assert property (scanTick && vMv <= actMv[i] && vMv >= relMv[i]
                                      |=> $stable(raw_q[i]))  // see [R14]
            else $error("raw state moved inside hysteresis band");

        restart_a: assert property (scanTick && target[i] == status_q[i]
                                    |=> elapsed_q[i] == '0)  // see [R14]
            else $error("pending delay not restarted");
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads, answer one cycle after the strobe

    logic [CH_W-1:0] rdCh;

    assign rdCh = chanOf(addr);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rdData <= '0;
        end
        else if (rdEn)
        begin
            rdData <= '0;
            if (addr == ADDR_STATUS_ALL)
            begin
                rdData[CHANNELS-1:0] <= status_q;
            end
            else if (chanHit(addr))
            begin
                case (regOf(addr))
                    REG_CFG:
                    begin
                        rdData[CFG_POL_BIT] <= cfg_q[rdCh].pol;
                        rdData[CFG_AC_BIT]  <= cfg_q[rdCh].ac;
                    end
                    REG_ACT_THR:  rdData[THR_W-1:0]  <= cfg_q[rdCh].actThr;
                    REG_REL_THR:  rdData[THR_W-1:0]  <= cfg_q[rdCh].relThr;
                    REG_ACT_DLY:  rdData[DLY_W-1:0]  <= cfg_q[rdCh].actDly;
                    REG_DROP_DLY: rdData[DLY_W-1:0]  <= cfg_q[rdCh].dropDly;
                    REG_COUNT:    rdData             <= count_q[rdCh];
                    REG_VOLT:     rdData[VOLT_W-1:0] <= voltIn[rdCh];  // see [R11]
                    REG_STATE:
                    begin
                        rdData[ST_STATUS_BIT] <= status_q[rdCh];
                        rdData[ST_RAW_BIT]    <= raw_q[rdCh];
                    end
                    default:      ;
                endcase
            end
        end
    end

    // status pins mirror the status flip-flops one cycle later
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            statusOut <= '0;
        end
        else
        begin
            statusOut <= status_q;
        end
    end

    volt_read_a: assert property (rdEn && addr == {1'b0, 3'h0, REG_VOLT}
                                  |=> rdData == {13'h0000, $past(voltIn[0])})  // see [R11]
        else $error("voltage read wrong");

    status_pin_a: assert property (1'b1 |=> statusOut == $past(status_q))  // see [R1]
        else $error("status pins out of step");

endmodule : dic_input_conditioner

`default_nettype wire

// *** tb/dic_afe_model.sv ***
// behavioural analog front end: one settled voltage per channel in mV
`default_nettype none

module dic_afe_model
    import dic_pkg::*;
#(
    parameter int unsigned CHANNELS = CHANNELS_DEF
)
(
    input  wire logic              clock,
    output var  logic [VOLT_W-1:0] volt [CHANNELS]
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        foreach (volt[i])
        begin
            volt[i] = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // new result lands just after an edge, like a converter output register
    task automatic setVolt(input int ch, input logic [VOLT_W-1:0] mv);
        @(posedge clock);
        volt[ch] <= mv;
    endtask : setVolt

endmodule : dic_afe_model

`default_nettype wire

// *** tb/digital_input_conditioner_bench.sv ***
// self-checking bench of the digital input conditioner
`default_nettype none

module digital_input_conditioner_bench
    import dic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // short scan so that delays of tens of ms stay cheap
    localparam int unsigned SCAN = 20;

    logic                    clock;
    logic                    rst_n;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       wrData;
    logic                    wrEn;
    logic                    rdEn;
    logic [DATA_W-1:0]       rdData;
    logic [VOLT_W-1:0]       voltIn [CHANNELS_DEF];
    logic [CHANNELS_DEF-1:0] statusOut;
    int                      n_mismatch = 0;
    int                      compares = 0;

    dic_input_conditioner #(.CHANNELS(CHANNELS_DEF), .SCAN_CYCLES(SCAN)) DUT (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData(rdData), .voltIn(voltIn), .statusOut(statusOut));

    dic_afe_model #(.CHANNELS(CHANNELS_DEF)) afe (.clock(clock), .volt(voltIn));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic stop_test();
        $display("mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // returns just after the edge so that registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc

    function automatic logic [ADDR_W-1:0] ra(input int ch, input logic [3:0] r);
        return {1'b0, 3'(ch), r};
    endfunction : ra

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        addr   <= a;
        wrData <= d;
        wrEn   <= 1'b1;
        @(posedge clock);
        wrEn   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clock);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clock);
        rdEn <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask : rd

    task automatic st(input int ch, input logic exp);
        chk(32'(statusOut[ch]), 32'(exp));
    endtask : st

    task automatic vs(input int ch, input int mv, input logic exp, input int w);
        afe.setVolt(ch, 19'(mv));
        cyc(w);
        st(ch, exp);
    endtask : vs

    // old level must hold for n scans, new level follows within the next one
    task automatic settle(input int ch, input logic exp, input int n);
        cyc(SCAN * n);
        st(ch, !exp);
        cyc(25);
        st(ch, exp);
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_defaults();
        rd(ra(0, REG_CFG), 32'h0);
        rd(ra(0, REG_ACT_THR), 32'h370);
        rd(ra(0, REG_REL_THR), 32'h258);
        rd(ra(0, REG_ACT_DLY), 32'h0);
        rd(ra(0, REG_DROP_DLY), 32'h0);
        rd(ra(7, REG_COUNT), 32'h0);
        rd(ra(0, 4'hf), 32'h0);
        rd(8'h90, 32'h0);
    endtask : t_defaults

    // voltages below are in mV: 88.000 V, 88.001 V, 70 V, 60 V, 59.999 V
    task automatic t_thresh();
        vs(0, 19'h157c0, 1'b0, 45);
        vs(0, 19'h157c1, 1'b1, 45);
        rd(ra(0, REG_COUNT), 32'h1);
        rd(ra(0, REG_VOLT), 32'h000157c1);
        vs(0, 19'h11170, 1'b1, 45);
        vs(0, 19'h0ea60, 1'b1, 45);
        vs(0, 19'h0ea5f, 1'b0, 45);
    endtask : t_thresh

    task automatic t_pol();
        wr(ra(1, REG_CFG), 32'h1);
        cyc(45);
        st(1, 1'b1);
        vs(1, 19'h157c1, 1'b0, 45);
        rd(ra(1, REG_CFG), 32'h1);
    endtask : t_pol

    // 10 ms pick-up, 7 ms drop-off; 100 V energizes, 0 V releases
    task automatic t_delay();
        wr(ra(2, REG_ACT_DLY), 32'h0000000a);
        wr(ra(2, REG_DROP_DLY), 32'h00000007);
        vs(2, 19'h186a0, 1'b0, 25);
        vs(2, 19'h00000, 1'b0, 25);
        afe.setVolt(2, 19'h186a0);
        settle(2, 1'b1, 2);
        afe.setVolt(2, 19'h00000);
        settle(2, 1'b0, 2);
        rd(ra(2, REG_COUNT), 32'h1);
    endtask : t_delay

    // release at 8.8 V in ac mode, the programmed 60 V is ignored
    task automatic t_ac();
        wr(ra(3, REG_CFG), 32'h2);
        vs(3, 19'h186a0, 1'b1, 45);
        vs(3, 19'h07530, 1'b1, 200);
        vs(3, 19'h02260, 1'b1, 200);
        afe.setVolt(3, 19'h0225f);
        settle(3, 1'b0, 6);
    endtask : t_ac

    // channel 4 picks up at 20 V, channel 5 keeps 88 V
    task automatic t_chan();
        wr(ra(4, REG_ACT_THR), 32'h000000c8);
        afe.setVolt(5, 19'h07530);
        vs(4, 19'h07530, 1'b1, 45);
        st(5, 1'b0);
        rd(ADDR_STATUS_ALL, 32'h10);
        rd(ra(4, REG_STATE), 32'h3);
    endtask : t_chan

    task automatic t_clear();
        wr(ra(0, REG_CLEAR), 32'h1);
        cyc(2);
        rd(ra(0, REG_COUNT), 32'h0);
        rd(ra(0, REG_CLEAR), 32'h0);
        // idle value written to another channel must not clear it
        wr(ra(2, REG_CLEAR), 32'h0);
        rd(ra(2, REG_COUNT), 32'h1);
        vs(0, 19'h186a0, 1'b1, 45);
        rd(ra(0, REG_COUNT), 32'h1);
    endtask : t_clear

    ////////////////////////////////////////////////////////////////////////////
    // sequence and watchdog
    initial
    begin
        rst_n  = 1'b0;
        addr   = '0;
        wrData = '0;
        wrEn   = 1'b0;
        rdEn   = 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_defaults();
        t_thresh();
        t_pol();
        t_delay();
        t_ac();
        t_chan();
        t_clear();
        stop_test();
    end

    // the whole sequence needs about 1260 cycles
    initial
    begin
        cyc(20000);
        n_mismatch++;
        stop_test();
    end

endmodule : digital_input_conditioner_bench

`default_nettype wire
